// >>> spi_cfg_pkg.sv
// Constants for the serial unit: register map, field layout and timing.
// Assumes a 32-bit APB bus with word-aligned registers and a 10 MHz pclk.
// Operation
// [R1] A clear width bit gives 8-bit transfers on the low byte; a set bit gives 16-bit words.
// [R2] In master mode, changing width, fault enable, pin select or either rate field aborts.
// [R3] In master bidirectional mode a change of the output enable bit aborts; otherwise not.
// [R4] A master with fault detect clear leaves the select pin unused; set with select output enable clear makes it a fault input.
// [R5] A slave always uses the select pin as an input.
// [R6] In bidirectional mode the output enable bit gates MOSI for a master and MISO for a slave.
// [R7] With pin select clear the master drives MOSI and reads MISO, the slave the reverse.
// [R8] A bidirectional master releases MISO and uses MOSI as input or input/output.
// [R9] A bidirectional slave releases MOSI and uses MISO as input or input/output.
// [R10] With wait clock stop set, the serial clock halts while the chip is in wait mode.
// [R11] The master divisor is (prescaler + 1) times two to the (exponent + 1).
// [R12] The master bit rate equals the bus clock divided by that divisor.
// [R13] Both configuration registers read and write at any time; reserved bits ignore writes.
// [R14] A master with fault detect and select output enable set drives the select pin out.
// [R15] An abort from a configuration change restarts the divider and the bit counter.
package spi_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL_ONE = 8'h00;
    localparam logic [7:0] IDX_CONTROL_TWO = 8'h01;
    localparam logic [7:0] IDX_BIT_RATE = 8'h02;
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_DATA_HIGH = 8'h04;
    localparam logic [7:0] IDX_DATA_LOW = 8'h05;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'(IDX_CONTROL_ONE * 4);
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'(IDX_CONTROL_TWO * 4);
    localparam logic [7:0] ADDR_BIT_RATE = 8'(IDX_BIT_RATE * 4);
    localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
    localparam logic [7:0] ADDR_DATA_HIGH = 8'(IDX_DATA_HIGH * 4);
    localparam logic [7:0] ADDR_DATA_LOW = 8'(IDX_DATA_LOW * 4);
    localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);

    // Control one fields
    localparam int BIT_ENABLE = 6;
    localparam int BIT_MASTER = 4;
    localparam int BIT_POLARITY = 3;
    localparam int BIT_SELECT_OUTPUT_ENABLE = 1;
    localparam logic [7:0] MASK_CONTROL_ONE = 8'h5a;
    // Control two fields
    localparam int BIT_WIDTH_SELECT = 6;
    localparam int BIT_FAULT_DETECT_ENABLE = 4;
    localparam int BIT_BIDIR_OUTPUT_ENABLE = 3;
    localparam int BIT_WAIT_CLOCK_STOP = 1;
    localparam int BIT_BIDIR_PIN_SELECT = 0;
    localparam logic [7:0] MASK_CONTROL_TWO = 8'h5b;
    localparam logic [7:0] MASK_ABORT_TWO = 8'h51;
    // Bit rate fields
    localparam int PRESCALER_LSB = 4;
    localparam int EXPONENT_LSB = 0;
    localparam logic [7:0] MASK_BIT_RATE = 8'h77;
    // Status and mask fields
    localparam int BIT_DONE_FLAG = 7;
    localparam int BIT_FAULT_FLAG = 4;
    localparam logic [7:0] MASK_STATUS = 8'h90;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] BITS_NARROW = 5'd8;
    localparam logic [4:0] BITS_WIDE = 5'd16;

    // Half of the serial clock period in bus cycles: (prescaler + 1) * 2^exponent
    function automatic logic [10:0] half_period(input logic [2:0] pre, input logic [2:0] expo);
        logic [10:0] base;
        base = {8'h00, pre} + 11'h001;
        return base << expo;
    endfunction
endpackage

// >>> serial_io_if.sv
// Signals passed between the serial core and its pin multiplexer.
// Assumes both ends run on pclk; every signal is a plain level.
`timescale 1ns/10ps
interface serial_io_if;
    logic enable;
    logic master;
    logic bidir;
    logic out_en;
    logic fault_en;
    logic sel_oe;
    logic busy;
    logic tx_bit;
    logic sck_level;
    logic rx_bit;
    logic sck_seen;
    logic ss_active;
    logic ss_fault;
    modport core (output enable, master, bidir, out_en, fault_en, sel_oe, busy, tx_bit,
                  sck_level, input rx_bit, sck_seen, ss_active, ss_fault);
    modport pins (input enable, master, bidir, out_en, fault_en, sel_oe, busy, tx_bit,
                  sck_level, output rx_bit, sck_seen, ss_active, ss_fault);
endinterface

// >>> baud_divider.sv
// Serial clock divider: one-cycle tick every half period of the bit clock.
// Assumes pclk is the bus clock and fields are stable or cleared on change.
`timescale 1ns/10ps
module baud_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic run,
    input wire logic [2:0] prescaler,
    input wire logic [2:0] exponent,
    output logic tick
);
    logic [10:0] count_reg;
    logic [10:0] count_next;
    logic [10:0] last_count;

    assign last_count = spi_cfg_pkg::half_period(prescaler, exponent) - 11'h001; // [R11]
    assign tick = run && !clear && (count_reg == last_count); // [R12]
    assign count_next = (clear || !run || tick) ? 11'h000 : count_reg + 11'h001; // [R15]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 11'h000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// >>> pin_mux.sv
// Pin routing for MOSI, MISO, SCK and the slave select line.
// Assumes pin inputs are synchronous to pclk; enables are high while driving.
`timescale 1ns/10ps
module pin_mux (
    input wire logic pclk,
    input wire logic presetn,
    serial_io_if.pins io,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ss_in_n,
    output logic ss_out_n,
    output logic ss_oe
);
    logic sck_prev_reg;
    logic slave_sel;
    logic master_on;

    assign master_on = io.enable && io.master;
    assign slave_sel = io.enable && !io.master && !ss_in_n; // [R5]
    // Master: normal drives MOSI; bidir gates MOSI by out_en and never drives MISO
    assign mosi_oe = master_on && (!io.bidir || io.out_en); // [R6] [R7] [R8]
    // Slave: MISO only while selected; bidir gates it by out_en and never drives MOSI
    assign miso_oe = slave_sel && (!io.bidir || io.out_en); // [R6] [R7] [R9]
    assign mosi_out = io.tx_bit;
    assign miso_out = io.tx_bit;
    assign io.rx_bit = (io.master != io.bidir) ? miso_in : mosi_in; // [R7] [R8] [R9]
    assign sck_oe = master_on;
    assign sck_out = io.sck_level;
    // Select output only with both enables in master mode
    assign ss_oe = master_on && io.fault_en && io.sel_oe; // [R14]
    assign ss_out_n = !io.busy;
    assign io.ss_active = slave_sel;
    assign io.ss_fault = master_on && io.fault_en && !io.sel_oe && !ss_in_n; // [R4]
    assign io.sck_seen = sck_in ^ sck_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_in;
        end
    end
endmodule

// >>> spi_width_pin_baud_config.sv
// Serial unit top: APB register file, shift engine and configuration aborts.
// Assumes a zero-wait APB master, synchronous pins and an external wait mode level.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module spi_width_pin_baud_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wait_mode,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ss_in_n,
    output logic ss_out_n,
    output logic ss_oe,
    output logic irq
);
    typedef enum logic {ST_IDLE, ST_SHIFT} engine_e;

    serial_io_if io ();

    engine_e state_reg;
    logic [7:0] control_one_reg;
    logic [7:0] serial_control_two_reg;
    logic [7:0] serial_bit_rate_reg;
    logic [7:0] status_reg;
    logic [7:0] mask_reg;
    logic [15:0] tx_hold_reg;
    logic [15:0] rx_data_reg;
    logic [15:0] shift_reg;
    logic [15:0] rx_shift_reg;
    logic [4:0] count_reg;
    logic sck_reg;

    logic access;
    logic wr;
    logic wr_one;
    logic wr_two;
    logic wr_rate;
    logic wr_status;
    logic wr_high;
    logic wr_low;
    logic wr_mask;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] diff_one;
    logic [7:0] diff_two;
    logic [7:0] diff_rate;
    logic master;
    logic enable;
    logic width_wide;
    logic [4:0] bits_needed;
    logic cfg_abort;
    logic abort;
    logic clock_run;
    logic tick;
    logic sample;
    logic shift;
    logic last_shift;
    logic done;
    logic start;
    logic [15:0] tx_load;
    logic [7:0] status_next;

    // APB decode; zero wait states, unmapped addresses answer with an error
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign wbyte = pwdata[7:0];
    assign wr_one = wr && (paddr == spi_cfg_pkg::ADDR_CONTROL_ONE);
    assign wr_two = wr && (paddr == spi_cfg_pkg::ADDR_CONTROL_TWO);
    assign wr_rate = wr && (paddr == spi_cfg_pkg::ADDR_BIT_RATE);
    assign wr_status = wr && (paddr == spi_cfg_pkg::ADDR_STATUS);
    assign wr_high = wr && (paddr == spi_cfg_pkg::ADDR_DATA_HIGH);
    assign wr_low = wr && (paddr == spi_cfg_pkg::ADDR_DATA_LOW);
    assign wr_mask = wr && (paddr == spi_cfg_pkg::ADDR_IRQ_MASK);
    assign mapped = (paddr == spi_cfg_pkg::ADDR_CONTROL_ONE)
        || (paddr == spi_cfg_pkg::ADDR_CONTROL_TWO)
        || (paddr == spi_cfg_pkg::ADDR_BIT_RATE)
        || (paddr == spi_cfg_pkg::ADDR_STATUS)
        || (paddr == spi_cfg_pkg::ADDR_DATA_HIGH)
        || (paddr == spi_cfg_pkg::ADDR_DATA_LOW)
        || (paddr == spi_cfg_pkg::ADDR_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            spi_cfg_pkg::ADDR_CONTROL_ONE: prdata[7:0] = control_one_reg;
            spi_cfg_pkg::ADDR_CONTROL_TWO: prdata[7:0] = serial_control_two_reg; // [R13]
            spi_cfg_pkg::ADDR_BIT_RATE: prdata[7:0] = serial_bit_rate_reg; // [R13]
            spi_cfg_pkg::ADDR_STATUS: prdata[7:0] = status_reg;
            spi_cfg_pkg::ADDR_DATA_HIGH: prdata[7:0] = rx_data_reg[15:8];
            spi_cfg_pkg::ADDR_DATA_LOW: prdata[7:0] = rx_data_reg[7:0];
            spi_cfg_pkg::ADDR_IRQ_MASK: prdata[7:0] = mask_reg;
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign enable = control_one_reg[spi_cfg_pkg::BIT_ENABLE];
    assign master = control_one_reg[spi_cfg_pkg::BIT_MASTER];
    assign width_wide = serial_control_two_reg[spi_cfg_pkg::BIT_WIDTH_SELECT];
    assign bits_needed = width_wide ? spi_cfg_pkg::BITS_WIDE : spi_cfg_pkg::BITS_NARROW; // [R1]

    // Configuration changes seen on the write strobe itself
    assign diff_one = (wbyte & spi_cfg_pkg::MASK_CONTROL_ONE) ^ control_one_reg;
    assign diff_two = (wbyte & spi_cfg_pkg::MASK_CONTROL_TWO) ^ serial_control_two_reg;
    assign diff_rate = (wbyte & spi_cfg_pkg::MASK_BIT_RATE) ^ serial_bit_rate_reg;
    assign cfg_abort = master && (
        (wr_two && ((diff_two & spi_cfg_pkg::MASK_ABORT_TWO) != 8'h00)) // [R2]
        || (wr_two && io.bidir && diff_two[spi_cfg_pkg::BIT_BIDIR_OUTPUT_ENABLE]) // [R3]
        || (wr_rate && (diff_rate != 8'h00)) // [R2]
        || (wr_one && (diff_one != 8'h00)))
        || (wr_one && diff_one[spi_cfg_pkg::BIT_MASTER]);
    assign abort = cfg_abort || io.ss_fault || !enable;

    // Wait mode may freeze the bit clock; the transfer resumes afterwards
    assign clock_run = (state_reg == ST_SHIFT) && master
        && !(serial_control_two_reg[spi_cfg_pkg::BIT_WAIT_CLOCK_STOP] && wait_mode); // [R10]

    baud_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(abort), // [R15]
        .run(clock_run),
        .prescaler(serial_bit_rate_reg[spi_cfg_pkg::PRESCALER_LSB +: 3]),
        .exponent(serial_bit_rate_reg[spi_cfg_pkg::EXPONENT_LSB +: 3]),
        .tick(tick)
    );

    assign io.enable = enable;
    assign io.master = master;
    assign io.bidir = serial_control_two_reg[spi_cfg_pkg::BIT_BIDIR_PIN_SELECT];
    assign io.out_en = serial_control_two_reg[spi_cfg_pkg::BIT_BIDIR_OUTPUT_ENABLE];
    assign io.fault_en = serial_control_two_reg[spi_cfg_pkg::BIT_FAULT_DETECT_ENABLE];
    assign io.sel_oe = control_one_reg[spi_cfg_pkg::BIT_SELECT_OUTPUT_ENABLE];
    assign io.busy = (state_reg == ST_SHIFT);
    assign io.tx_bit = shift_reg[15];
    assign io.sck_level = sck_reg ^ control_one_reg[spi_cfg_pkg::BIT_POLARITY];

    pin_mux u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .io(io.pins),
        .mosi_in(mosi_in),
        .mosi_out(mosi_out),
        .mosi_oe(mosi_oe),
        .miso_in(miso_in),
        .miso_out(miso_out),
        .miso_oe(miso_oe),
        .sck_in(sck_in),
        .sck_out(sck_out),
        .sck_oe(sck_oe),
        .ss_in_n(ss_in_n),
        .ss_out_n(ss_out_n),
        .ss_oe(ss_oe)
    );

    // Leading edge samples, trailing edge shifts; slave follows the pin clock
    assign sample = (master && tick && !sck_reg)
        || (!master && io.ss_active && io.sck_seen && !sck_reg);
    assign shift = (master && tick && sck_reg)
        || (!master && io.ss_active && io.sck_seen && sck_reg);
    assign last_shift = shift && (count_reg == bits_needed - 5'd1);
    assign done = last_shift && (state_reg == ST_SHIFT) && !abort;
    assign start = enable && (state_reg == ST_IDLE) && !abort
        && ((master && wr_low) || (!master && io.ss_active));
    // Narrow data sits in the top byte so bit 15 leaves first
    assign tx_load = width_wide ? {tx_hold_reg[15:8], wbyte} : {wbyte, 8'h00}; // [R1]

    assign status_next = (status_reg
        & ~(wr_status ? (wbyte & spi_cfg_pkg::MASK_STATUS) : 8'h00))
        | {done, 2'b00, io.ss_fault, 4'h0};
    assign irq = (status_reg & mask_reg) != 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_one_reg <= spi_cfg_pkg::RESET_BYTE;
            serial_control_two_reg <= spi_cfg_pkg::RESET_BYTE;
            serial_bit_rate_reg <= spi_cfg_pkg::RESET_BYTE;
            mask_reg <= spi_cfg_pkg::RESET_BYTE;
            status_reg <= spi_cfg_pkg::RESET_BYTE;
        end else begin
            if (wr_one) begin
                control_one_reg <= wbyte & spi_cfg_pkg::MASK_CONTROL_ONE;
            end
            if (wr_two) begin
                serial_control_two_reg <= wbyte & spi_cfg_pkg::MASK_CONTROL_TWO; // [R13]
            end
            if (wr_rate) begin
                serial_bit_rate_reg <= wbyte & spi_cfg_pkg::MASK_BIT_RATE; // [R13]
            end
            if (wr_mask) begin
                mask_reg <= wbyte & spi_cfg_pkg::MASK_STATUS;
            end
            status_reg <= status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_reg <= 16'h0000;
        end else if (wr_high) begin
            tx_hold_reg[15:8] <= wbyte;
        end else if (wr_low) begin
            tx_hold_reg[7:0] <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            shift_reg <= 16'h0000;
            rx_shift_reg <= 16'h0000;
            count_reg <= 5'd0;
            sck_reg <= 1'b0;
        end else if (abort) begin
            state_reg <= ST_IDLE; // [R2] [R3]
            count_reg <= 5'd0; // [R15]
            sck_reg <= 1'b0;
        end else if (start) begin
            state_reg <= ST_SHIFT;
            shift_reg <= master ? tx_load : (width_wide ? tx_hold_reg : {tx_hold_reg[7:0], 8'h00});
            count_reg <= 5'd0;
        end else if (state_reg == ST_SHIFT) begin
            if (sample) begin
                rx_shift_reg <= {rx_shift_reg[14:0], io.rx_bit};
                sck_reg <= 1'b1;
            end
            if (shift) begin
                shift_reg <= {shift_reg[14:0], 1'b0};
                count_reg <= count_reg + 5'd1;
                sck_reg <= 1'b0;
            end
            if (done) begin
                state_reg <= ST_IDLE;
                count_reg <= 5'd0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_reg <= 16'h0000;
        end else if (done) begin
            rx_data_reg <= width_wide ? rx_shift_reg : {8'h00, rx_shift_reg[7:0]}; // [R1]
        end
    end

    // Helper: cycles since the last divider tick
    logic [11:0] gap_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= 12'h000;
        end else if (tick || !clock_run) begin
            gap_reg <= 12'h001;
        end else begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_narrow_high_zero: assert property (done && !width_wide |=> rx_data_reg[15:8] == 8'h00) // [R1]
        else $error("narrow transfer left data in the high byte");
    a_cfg_abort_idle: assert property (cfg_abort && io.busy |=> !io.busy && count_reg == 5'd0) // [R2]
        else $error("configuration change did not abort the transfer");
    a_bidir_oe_abort: assert property (
        master && io.busy && io.bidir && wr_two && diff_two[spi_cfg_pkg::BIT_BIDIR_OUTPUT_ENABLE]
        |=> state_reg == ST_IDLE) // [R3]
        else $error("output enable change in bidirectional mode did not abort");
    a_ss_unused: assert property (master && !io.fault_en |-> !ss_oe && !io.ss_fault) // [R4]
        else $error("select pin used with fault detect disabled");
    a_slave_ss_input: assert property (!master |-> !ss_oe) // [R5]
        else $error("slave drove the select pin");
    a_oe_gates_buffer: assert property (io.bidir && !io.out_en |-> !mosi_oe && !miso_oe) // [R6]
        else $error("output buffer enabled with bidirectional enable clear");
    a_normal_pins: assert property (enable && master && !io.bidir |-> mosi_oe && !miso_oe
        && io.rx_bit == miso_in) // [R7]
        else $error("normal master pin routing wrong");
    a_master_bidir: assert property (master && io.bidir |-> !miso_oe && io.rx_bit == mosi_in) // [R8]
        else $error("bidirectional master used MISO");
    a_slave_bidir: assert property (!master && io.bidir |-> !mosi_oe && io.rx_bit == miso_in) // [R9]
        else $error("bidirectional slave used MOSI");
    a_wait_clock_held: assert property (
        serial_control_two_reg[spi_cfg_pkg::BIT_WAIT_CLOCK_STOP] && wait_mode && !abort
        |=> $stable(sck_reg) && !tick) // [R10]
        else $error("serial clock moved in wait mode");
    a_tick_spacing: assert property (tick && !$past(tick) && $past(clock_run) // [R11]
        |-> gap_reg == {1'b0, spi_cfg_pkg::half_period(serial_bit_rate_reg[6:4],
        serial_bit_rate_reg[2:0])})
        else $error("divider half period wrong");
    a_bit_period: assert property (clock_run |-> gap_reg <= {1'b0, // [R12]
        spi_cfg_pkg::half_period(serial_bit_rate_reg[6:4], serial_bit_rate_reg[2:0])})
        else $error("serial clock stalled in master transfer");
    a_ss_output: assert property (enable && master && io.fault_en && io.sel_oe
        |-> ss_oe && ss_out_n == !io.busy) // [R14]
        else $error("select output not driven");
    a_abort_restart: assert property (abort |=> count_reg == 5'd0 && !sck_reg && !tick) // [R15]
        else $error("abort did not restart the counters");
endmodule

// >>> spi_peer_model.sv
// Serial peer on the far side: answers with a reply word, records what the master sent.
// Assumes mode 0 timing, sck idle low and sck changing only just after pclk edges.
`timescale 1ns/10ps
module spi_peer_model (
    input wire logic pclk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic active,
    input wire logic load,
    input wire logic [15:0] reply,
    output logic miso,
    output logic [15:0] got
);
    logic sck_q = 1'b0;
    logic last = 1'b0;
    logic [15:0] sh = 16'h0000;
    // Released line flips, so a stale bit can never pass for data
    assign miso = active ? sh[15] : ~last;
    always @(posedge pclk) begin
        sck_q <= sck;
        if (active) begin
            last <= sh[15];
        end
        if (load) begin
            sh <= reply;
            got <= 16'h0000;
        end else if (sck && !sck_q) begin
            got <= {got[14:0], mosi};
        end else if (!sck && sck_q) begin
            sh <= {sh[14:0], 1'b0};
        end
    end
endmodule

// >>> spi_width_pin_baud_config_tb_top.sv
// Self-checking bench: APB register access, transfers, aborts, wait stop, pins, faults.
// Assumes the zero-wait APB slave and the peer model beside it.
`timescale 1ns/10ps
module spi_width_pin_baud_config_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wait_mode = 1'b0;
    logic ss_in_n = 1'b1;
    logic load = 1'b0;
    logic [15:0] reply = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe;
    logic ss_out_n, ss_oe, irq, peer_miso, last_err;
    logic [15:0] got;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    wire logic mosi_in = mosi_oe ? mosi_out : ~mosi_out;
    wire logic miso_in = miso_oe ? miso_out : peer_miso;
    spi_width_pin_baud_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .wait_mode, .mosi_in, .mosi_out, .mosi_oe,
        .miso_in, .miso_out, .miso_oe, .sck_in(1'b0), .sck_out, .sck_oe, .ss_in_n,
        .ss_out_n, .ss_oe, .irq);
    spi_peer_model peer (.pclk, .sck(sck_out), .mosi(mosi_out), .active(1'b1), .load,
        .reply, .miso(peer_miso), .got);
    always #50 pclk = ~pclk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 8'h00, q);
        check(what, q, exp);
    endtask
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic xfer(input logic wide, input logic [15:0] d, input logic [15:0] r, input int dur);
        int n;
        reply <= wide ? r : {r[7:0], 8'h00};
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        if (wide) w(8'h10, d[15:8]);
        w(8'h14, d[7:0]);
        wait_irq(3000, n);
        check("duration", {31'h0, n >= dur - 2 && n <= dur + 1}, 32'h1);
        rc("rx low", 8'h14, {24'h0, r[7:0]});
        rc("rx high", 8'h10, {24'h0, wide ? r[15:8] : 8'h00});
        check("peer got", {16'h0, got}, {16'h0, wide ? d : {8'h00, d[7:0]}});
        w(8'h0c, 8'h80);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_regs();
        rc("ctl2 reset", 8'h04, 32'h0);
        rc("rate reset", 8'h08, 32'h0);
        w(8'h04, 8'hff);
        rc("ctl2 rw", 8'h04, 32'h5b);
        w(8'h08, 8'hff);
        rc("rate rw", 8'h08, 32'h77);
        rc("unmapped", 8'h1c, 32'h0);
        check("unmapped err", {31'h0, last_err}, 32'h1);
        w(8'h04, 8'h00);
        $display("registers done");
    endtask
    task automatic t_xfer();
        logic [24:0] tbl [6] = '{25'h0000440, 25'h0000410, 25'h0000401, 25'h0000812,
                                 25'h0010409, 25'h1000408};
        w(8'h00, 8'h50);
        w(8'h20, 8'h80);
        w(8'h08, 8'h11);
        xfer(1'b0, 16'h00a5, 16'h003c, 64);
        w(8'h08, 8'h20);
        xfer(1'b0, 16'h0096, 16'h00e1, 48);
        w(8'h08, 8'h11);
        w(8'h04, 8'h40);
        xfer(1'b1, 16'hc381, 16'h5a0f, 128);
        for (int i = 0; i < 6; i++) begin
            w(8'h04, tbl[i][23:16]);
            w(8'h08, 8'h11);
            w(8'h14, 8'h5a);
            repeat (20) @(posedge pclk);
            w(tbl[i][15:8], tbl[i][7:0]);
            repeat (80) @(posedge pclk);
            check("done after change", {31'h0, irq}, {31'h0, tbl[i][24]});
            check("sck idle", {31'h0, sck_out}, 32'h0);
            w(8'h0c, 8'h80);
        end
        w(8'h04, 8'h00);
        w(8'h08, 8'h11);
        // A fresh transfer after the aborts must still take the full count
        xfer(1'b0, 16'h0081, 16'h0042, 64);
        $display("transfers done");
    endtask
    task automatic t_wait();
        logic s;
        int k;
        w(8'h04, 8'h02);
        w(8'h14, 8'h33);
        repeat (8) @(posedge pclk);
        wait_mode <= 1'b1;
        @(posedge pclk);
        s = sck_out;
        k = 0;
        repeat (40) begin
            @(posedge pclk);
            if (sck_out !== s) k++;
        end
        check("sck frozen", k, 0);
        check("no done in wait", {31'h0, irq}, 32'h0);
        wait_mode <= 1'b0;
        wait_irq(200, k);
        check("done after wait", {31'h0, irq}, 32'h1);
        w(8'h0c, 8'h80);
        w(8'h04, 8'h00);
        wait_mode <= 1'b1;
        xfer(1'b0, 16'h0069, 16'h00c6, 64);
        wait_mode <= 1'b0;
        $display("wait mode done");
    endtask
    task automatic t_pins();
        logic [19:0] pt [11] = '{20'h5000c, 20'h50018, 20'h5009c, 20'h5010c, 20'h5210d,
            20'h5200c, 20'h40002, 20'h40010, 20'h40092, 20'h42102, 20'h40008};
        for (int i = 0; i < 11; i++) begin
            ss_in_n <= pt[i][3];
            w(8'h00, pt[i][19:12]);
            w(8'h04, pt[i][11:4]);
            check("pin enables", {29'h0, mosi_oe, miso_oe, ss_oe},
                {29'h0, pt[i][2:0]});
            check("sck enable", {31'h0, sck_oe}, {31'h0, pt[i][18] & pt[i][16]});
        end
        w(8'h00, 8'h50);
        w(8'h04, 8'h10);
        w(8'h20, 8'h10);
        ss_in_n <= 1'b0;
        repeat (4) @(posedge pclk);
        check("fault irq", {31'h0, irq}, 32'h1);
        ss_in_n <= 1'b1;
        w(8'h0c, 8'h10);
        check("fault cleared", {31'h0, irq}, 32'h0);
        w(8'h20, 8'h00);
        ss_in_n <= 1'b0;
        repeat (4) @(posedge pclk);
        ss_in_n <= 1'b1;
        check("fault masked", {31'h0, irq}, 32'h0);
        rc("fault sticky", 8'h0c, 32'h10);
        $display("pins done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_xfer();
        t_wait();
        t_pins();
        summarize();
    end
endmodule
